// >>> rtl/ddsag_top.sv
// dds phase accumulator, waveform memory, modulation and output selects
`timescale 1ns/1ps
`default_nettype none
module ddsag_top
	import ddsag_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// converter samples
	output logic [DW-1:0] dac_data,
	output logic dac_valid,
	input wire logic dac_ready,
	// analog path controls
	input wire logic comp_in,
	output logic filt_ellip,
	output logic am_src_ext,
	output logic [DW-1:0] am_level,
	output logic sq_path,
	output logic sync_out,
	output logic [2:0] atten
);
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic ddsag_func_t fn_dec(input logic [2:0] c);
		case (c)
			3'h1: fn_dec = FN_SQUARE;
			3'h2: fn_dec = FN_TRI;
			3'h3: fn_dec = FN_RAMP;
			3'h4: fn_dec = FN_ARB;
			default: fn_dec = FN_SINE;
		endcase
	endfunction

	function automatic ddsag_mod_t mt_dec(input logic en,
			input logic [2:0] c);
		if (!en) begin
			mt_dec = MT_NONE;
		end else begin
			case (c)
				3'h1: mt_dec = MT_AM;
				3'h2: mt_dec = MT_FM;
				3'h3: mt_dec = MT_PM;
				3'h4: mt_dec = MT_BURST;
				3'h5: mt_dec = MT_SWEEP;
				default: mt_dec = MT_NONE;
			endcase
		end
	endfunction

	// --------------------------------------------------------------
	// register bus
	// --------------------------------------------------------------
	logic [PW-1:0] step_base_r, step_base_nxt;
	logic [31:0] ctrl_r, ctrl_nxt, rate_r, rate_nxt, dev_r, dev_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_ofs_r, wr_ofs_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [PW-1:0] acc_r, acc_nxt;
	logic ap, wave_we, mod_we;
	ddsag_func_t fn;
	ddsag_mod_t mt;

	assign ap = hsel & hready & htrans[1];
	assign fn = fn_dec(ctrl_r[CTRL_FN_LSB +: 3]);
	assign mt = mt_dec(ctrl_r[CTRL_MEN_BIT], ctrl_r[CTRL_MT_LSB +: 3]);
	assign wave_we = wr_pend_r & (wr_ofs_r == OFS_WAVE_WR);
	assign mod_we = wr_pend_r & (wr_ofs_r == OFS_MODRAM_WR);

	always_comb begin
		wr_pend_nxt = ap & hwrite;
		wr_ofs_nxt = ap ? haddr[7:0] : wr_ofs_r;
		step_base_nxt = step_base_r;
		ctrl_nxt = ctrl_r;
		rate_nxt = rate_r;
		dev_nxt = dev_r;
		if (wr_pend_r) begin
			case (wr_ofs_r)
				// step write takes effect without touching acc_r
				OFS_STEP_LO: step_base_nxt[31:0] = hwdata;
				OFS_STEP_HI: step_base_nxt[PW-1:32] = hwdata[15:0];
				OFS_CTRL: ctrl_nxt = hwdata;
				OFS_MOD_RATE: rate_nxt = hwdata;
				OFS_MOD_DEV: dev_nxt = hwdata;
				default: ctrl_nxt = ctrl_r;
			endcase
		end
		hrdata_nxt = 32'h0000_0000;
		if (ap & !hwrite) begin
			case (haddr[7:0])
				OFS_STEP_LO: hrdata_nxt = step_base_r[31:0];
				OFS_STEP_HI: hrdata_nxt = {16'h0000, step_base_r[PW-1:32]};
				OFS_CTRL: hrdata_nxt = ctrl_r;
				OFS_MOD_RATE: hrdata_nxt = rate_r;
				OFS_MOD_DEV: hrdata_nxt = dev_r;
				OFS_STATUS: hrdata_nxt = acc_r[PW-1 -: 32];
				default: hrdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_ofs_r <= 8'h00;
			step_base_r <= STEP_RST;
			ctrl_r <= CTRL_RST;
			rate_r <= RATE_RST;
			dev_r <= DEV_RST;
			hrdata_r <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_ofs_r <= wr_ofs_nxt;
			step_base_r <= step_base_nxt;
			ctrl_r <= ctrl_nxt;
			rate_r <= rate_nxt;
			dev_r <= dev_nxt;
			hrdata_r <= hrdata_nxt;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	assign hrdata = hrdata_r;

	// --------------------------------------------------------------
	// memories
	// --------------------------------------------------------------
	logic [DW-1:0] wave_ram [2**WAW];
	logic [MDW-1:0] mod_ram [2**MAW];
	logic [DW-1:0] samp_r;
	logic [MDW-1:0] msmp_r;
	logic [MAW-1:0] midx_r, midx_nxt;
	logic adv;

	always_ff @(posedge hclk) begin
		if (wave_we) begin
			wave_ram[hwdata[RAM_ADDR_LSB +: WAW]] <= hwdata[DW-1:0];
		end
		if (mod_we) begin
			mod_ram[hwdata[RAM_ADDR_LSB +: MAW]] <= hwdata[MDW-1:0];
		end
		// one-cycle read, address from accumulator msbs
		if (adv) begin
			samp_r <= wave_ram[acc_r[PW-1 -: WAW]];
		end
		msmp_r <= mod_ram[midx_r];
	end

	// --------------------------------------------------------------
	// sample rate divider and modulation processor
	// --------------------------------------------------------------
	logic [2:0] div_r, div_nxt;
	logic smp_en_r, smp_en_nxt;
	logic [31:0] rcnt_r, rcnt_nxt;
	logic [PW-1:0] sweep_r, sweep_nxt, step_eff_r, step_eff_nxt;
	logic [PW-1:0] fm_ofs, pm_add, dev_ext;
	logic [MDW-1:0] pm_last_r, pm_last_nxt;
	logic tick;

	assign tick = smp_en_r & (rcnt_r == rate_r) & (mt != MT_NONE);
	assign dev_ext = PW'(signed'(dev_r));
	assign fm_ofs = PW'(signed'(dev_ext) * signed'(PW'(signed'(msmp_r))));
	assign pm_add = (mt == MT_PM) ?
		{MDW'(msmp_r - pm_last_r), 32'h0000_0000} : '0;

	always_comb begin
		div_nxt = (div_r == SMP_DIV_M1) ? 3'h0 : div_r + 3'h1;
		smp_en_nxt = div_r == SMP_DIV_M1;
		rcnt_nxt = rcnt_r;
		midx_nxt = midx_r;
		sweep_nxt = sweep_r;
		if (mt == MT_NONE) begin
			rcnt_nxt = 32'h0000_0000;
			midx_nxt = '0;
			sweep_nxt = '0;
		end else if (tick) begin
			rcnt_nxt = 32'h0000_0000;
			midx_nxt = midx_r + 1'b1;
			// sweep restarts when the table wraps
			sweep_nxt = (midx_r == '1) ? '0 : sweep_r + dev_ext;
		end else if (smp_en_r) begin
			rcnt_nxt = rcnt_r + 32'h0000_0001;
		end
		case (mt)
			MT_FM: step_eff_nxt = step_base_r + fm_ofs;
			MT_SWEEP: step_eff_nxt = step_base_r + sweep_r;
			default: step_eff_nxt = step_base_r;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= 3'h0;
			smp_en_r <= 1'b0;
			rcnt_r <= 32'h0000_0000;
			midx_r <= '0;
			sweep_r <= STEP_RST;
			step_eff_r <= STEP_RST;
		end else begin
			div_r <= div_nxt;
			smp_en_r <= smp_en_nxt;
			rcnt_r <= rcnt_nxt;
			midx_r <= midx_nxt;
			sweep_r <= sweep_nxt;
			step_eff_r <= step_eff_nxt;
		end
	end

	// --------------------------------------------------------------
	// phase accumulator and sample stream
	// --------------------------------------------------------------
	logic samp_vld_r, fifo_in_rdy, fifo_ov, pop;
	logic [DW-1:0] fifo_od;
	logic [DW-1:0] dac_data_r, dac_data_nxt;
	logic dac_valid_r, dac_valid_nxt;

	// a full fifo stalls the accumulator rather than drop samples
	assign adv = smp_en_r & fifo_in_rdy;
	assign pop = fifo_ov & (~dac_valid_r | dac_ready);

	always_comb begin
		// natural 48-bit wrap; pm adds only the phase change
		acc_nxt = adv ? acc_r + step_eff_r + pm_add : acc_r;
		pm_last_nxt = (adv & (mt == MT_PM)) ? msmp_r : pm_last_r;
		dac_data_nxt = pop ? fifo_od : dac_data_r;
		dac_valid_nxt = pop | (dac_valid_r & ~dac_ready);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_r <= STEP_RST;
			pm_last_r <= '0;
			samp_vld_r <= 1'b0;
			dac_data_r <= '0;
			dac_valid_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			pm_last_r <= pm_last_nxt;
			samp_vld_r <= adv;
			dac_data_r <= dac_data_nxt;
			dac_valid_r <= dac_valid_nxt;
		end
	end
	assign dac_data = dac_data_r;
	assign dac_valid = dac_valid_r;

	ddsag_fifo #(.WIDTH(DW), .DEPTH(FIFO_D)) u_fifo (
		.clk(hclk),
		.rst_n(hresetn),
		.in_valid(samp_vld_r),
		.in_data(samp_r),
		.in_ready(fifo_in_rdy),
		.out_valid(fifo_ov),
		.out_data(fifo_od),
		.out_ready(pop)
	);

	// --------------------------------------------------------------
	// analog path selects
	// --------------------------------------------------------------
	logic filt_nxt, sq_nxt;
	logic [DW-1:0] am_nxt;

	always_comb begin
		// square is made from the filtered sine, so it shares its path
		filt_nxt = (fn == FN_SINE) | (fn == FN_SQUARE);
		sq_nxt = fn == FN_SQUARE;
		case (mt)
			MT_AM: am_nxt = msmp_r[MDW-1 -: DW];
			MT_BURST: am_nxt = msmp_r[0] ? AM_FULL : '0;
			default: am_nxt = AM_FULL;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filt_ellip <= 1'b1;
			sq_path <= 1'b0;
			am_level <= AM_FULL;
			am_src_ext <= 1'b0;
			atten <= 3'h0;
			sync_out <= 1'b0;
		end else begin
			filt_ellip <= filt_nxt;
			sq_path <= sq_nxt;
			am_level <= am_nxt;
			am_src_ext <= ctrl_r[CTRL_AMX_BIT];
			atten <= ctrl_r[CTRL_ATT_LSB +: 3];
			sync_out <= comp_in;
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_smp_gap;
		!smp_en_r [*4] ##1 smp_en_r;
	endsequence

	a_acc_add: assert property (adv |=> acc_r ==
		$past(acc_r) + $past(step_eff_r) + $past(pm_add))
		else $error("accumulator did not add step");
	a_acc_hold: assert property (!adv |=> $stable(acc_r))
		else $error("accumulator moved without sample enable");
	a_samp_lat: assert property (adv |=> samp_vld_r ##1 !samp_vld_r)
		else $error("sample latency wrong");
	a_smp_rate: assert property (smp_en_r |=> s_smp_gap)
		else $error("sample enable not every fifth clock");
	a_step_take: assert property ((mt == MT_NONE) && $changed(step_base_r)
		|=> step_eff_r == $past(step_base_r))
		else $error("new step not applied in one cycle");
	a_filt_sel: assert property ($past(fn) inside {FN_TRI, FN_RAMP, FN_ARB}
		|-> !filt_ellip)
		else $error("bessel path not selected");
	a_am_src: assert property (am_src_ext == $past(ctrl_r[CTRL_AMX_BIT]))
		else $error("am source select wrong");
	a_atten_set: assert property (atten == $past(ctrl_r[CTRL_ATT_LSB +: 3]))
		else $error("attenuator enables wrong");
	a_sync_follow: assert property (sync_out == $past(comp_in))
		else $error("sync does not follow comparator");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready okay");
endmodule
`default_nettype wire

// >>> rtl/ddsag_pkg.sv
// constants and types for the dds phase address generator
package ddsag_pkg;
	// --------------------------------------------------------------
	// clocking
	// --------------------------------------------------------------
	localparam int CLK_HZ = 200_000_000;
	localparam int SMP_HZ = 40_000_000;
	localparam int SMP_DIV = CLK_HZ / SMP_HZ;
	localparam logic [2:0] SMP_DIV_M1 = 3'(SMP_DIV - 1);
	// --------------------------------------------------------------
	// widths and depths
	// --------------------------------------------------------------
	localparam int PW = 48;
	localparam int DW = 12;
	localparam int WAW = 12;
	localparam int MAW = 8;
	localparam int MDW = 16;
	localparam int FIFO_D = 32;
	// --------------------------------------------------------------
	// register byte offsets
	// --------------------------------------------------------------
	localparam logic [7:0] OFS_STEP_LO = 8'h00;
	localparam logic [7:0] OFS_STEP_HI = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_MOD_RATE = 8'h0c;
	localparam logic [7:0] OFS_MOD_DEV = 8'h10;
	localparam logic [7:0] OFS_WAVE_WR = 8'h14;
	localparam logic [7:0] OFS_MODRAM_WR = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	// --------------------------------------------------------------
	// control fields and reset values
	// --------------------------------------------------------------
	localparam int CTRL_FN_LSB = 0;
	localparam int CTRL_AMX_BIT = 3;
	localparam int CTRL_ATT_LSB = 4;
	localparam int CTRL_MT_LSB = 7;
	localparam int CTRL_MEN_BIT = 10;
	localparam int RAM_ADDR_LSB = 16;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] RATE_RST = 32'h0000_0000;
	localparam logic [31:0] DEV_RST = 32'h0000_0000;
	localparam logic [PW-1:0] STEP_RST = 48'h0000_0000_0000;
	localparam logic [DW-1:0] AM_FULL = 12'hfff;
	typedef enum logic [4:0] {
		FN_SINE = 5'b00001,
		FN_SQUARE = 5'b00010,
		FN_TRI = 5'b00100,
		FN_RAMP = 5'b01000,
		FN_ARB = 5'b10000
	} ddsag_func_t;
	typedef enum logic [5:0] {
		MT_NONE = 6'b000001,
		MT_AM = 6'b000010,
		MT_FM = 6'b000100,
		MT_PM = 6'b001000,
		MT_BURST = 6'b010000,
		MT_SWEEP = 6'b100000
	} ddsag_mod_t;
endpackage

// >>> rtl/ddsag_fifo.sv
// sample fifo between waveform memory and converter
`timescale 1ns/1ps
`default_nettype none
module ddsag_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rp_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule
`default_nettype wire

// >>> dv/ddsag_dac_sink.sv
// converter sink model: random acceptance, stall on request
`timescale 1ns/1ps
`default_nettype none
module ddsag_dac_sink
	import ddsag_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// sample stream
	input wire logic [DW-1:0] dac_data,
	input wire logic dac_valid,
	output logic dac_ready,
	// bench control
	input wire logic stall
);
	integer sk_seed = 32'h1234_5678;
	// ready is not tied to valid: a real converter takes on its own beat
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_ready <= 1'b0;
		end else begin
			dac_ready <= !stall && ($random(sk_seed) % 4 != 0);
		end
	end
endmodule
`default_nettype wire

// >>> dv/ddsag_top_test.sv
// self-checking bench for the dds phase address generator
`timescale 1ns/1ps
`default_nettype none
module ddsag_top_test
	import ddsag_pkg::*;
;
	// ----------
	// bench setup
	// ----------
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r, a, k, mm, dh;
	logic [1:0] htrans;
	logic [2:0] hsize, atten;
	logic [DW-1:0] dac_data, am_level, first_v, prev;
	logic dac_valid, dac_ready, comp_in, comp_q, filt_ellip, am_src_ext;
	logic sq_path, sync_out, stall, cnt_run, diverged;
	logic chk_wave, chk_sync, have_prev;
	integer same_n = 0;
	integer seed = 32'he6232db7;
	integer mismatches = 0;
	integer tests_run = 0;
	integer n, i;
	localparam logic [DW-1:0] WX = 12'ha5c;
	assign hready = hreadyout;
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	ddsag_top ddsag_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .dac_data(dac_data),
		.dac_valid(dac_valid), .dac_ready(dac_ready), .comp_in(comp_in),
		.filt_ellip(filt_ellip), .am_src_ext(am_src_ext),
		.am_level(am_level), .sq_path(sq_path), .sync_out(sync_out),
		.atten(atten));
	ddsag_dac_sink ddsag_dac_sink_i (.clk(hclk), .rst_n(hresetn),
		.dac_data(dac_data), .dac_valid(dac_valid),
		.dac_ready(dac_ready), .stall(stall));
	function automatic logic [DW-1:0] wave(input logic [DW-1:0] ad);
		return ad ^ WX;
	endfunction
	function automatic logic ellip(input int fn);
		return fn != 2 && fn != 3 && fn != 4;
	endfunction
	task check(input logic [31:0] exp, input logic [31:0] got);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= ad;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// consecutive samples must walk the memory one address at a time
	always @(posedge hclk) begin
		if (chk_wave && dac_valid === 1'b1 && dac_ready === 1'b1) begin
			if (have_prev) check(wave(wave(prev) + 1'b1), dac_data);
			prev = dac_data;
			have_prev = 1'b1;
		end
		// run length of the first value after a frozen-phase backlog
		if (cnt_run && dac_valid === 1'b1 && dac_ready === 1'b1) begin
			if (same_n == 0) first_v = dac_data;
			if (!diverged && dac_data === first_v) begin
				same_n = same_n + 1;
			end else begin
				diverged = 1'b1;
			end
		end
		if (chk_sync) check(comp_q, sync_out);
		comp_q = comp_in;
	end
	initial begin
		#250000;
		mismatches = mismatches + 1;
		close_out;
	end
	// ----------
	// test sequence
	// ----------
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, comp_in} = '0;
		{stall, cnt_run, diverged, chk_wave, chk_sync, have_prev} = '0;
		comp_q = 1'b0;
		hsize = 3'b010;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		check(1, filt_ellip);
		check(AM_FULL, am_level);
		check(0, atten);
		bus(1, 32'h0000_0020, 32'hffff_ffff);
		bus(0, 32'h0000_0020, 0);
		check(0, r);
		for (i = 0; i < 8; i++) begin
			k = ($random(seed) & 32'h0000_0078) | i;
			bus(1, OFS_CTRL, k);
			repeat (3) @(posedge hclk);
			check(ellip(i), filt_ellip);
			check(i == 1, sq_path);
			check(k[3], am_src_ext);
			check(k[6:4], atten);
		end
		bus(1, OFS_CTRL, 0);
		// reads 50 clocks apart span exactly ten sample ticks
		for (i = 0; i < 4; i++) begin
			k = (i == 0) ? 32'hffff_ffff : $random(seed);
			bus(1, OFS_STEP_LO, {k[15:0], 16'h0000});
			bus(1, OFS_STEP_HI, {16'h0000, k[31:16]});
			bus(0, OFS_STATUS, 0);
			a = r;
			repeat (47) @(posedge hclk);
			bus(0, OFS_STATUS, 0);
			check(a + 10 * k, r);
		end
		bus(1, OFS_STEP_LO, 0);
		bus(1, OFS_STEP_HI, 0);
		bus(0, OFS_STATUS, 0);
		a = r;
		repeat (20) @(posedge hclk);
		bus(0, OFS_STATUS, 0);
		check(a, r);
		for (i = 0; i < 4096; i++) begin
			bus(1, OFS_WAVE_WR, {4'h0, 12'(i), 4'h0, wave(12'(i))});
		end
		bus(1, OFS_STEP_HI, 32'h0000_0010);
		repeat (300) @(posedge hclk);
		chk_wave = 1'b1;
		repeat (300) @(posedge hclk);
		stall <= 1'b1;
		repeat (400) @(posedge hclk);
		stall <= 1'b0;
		repeat (600) @(posedge hclk);
		chk_wave = 1'b0;
		// freeze the phase, fill the buffer, then give a step while full
		bus(1, OFS_STEP_HI, 0);
		repeat (50) @(posedge hclk);
		stall <= 1'b1;
		repeat (300) @(posedge hclk);
		bus(0, OFS_STATUS, 0);
		a = r;
		bus(1, OFS_STEP_HI, 32'h0000_0010);
		repeat (20) @(posedge hclk);
		bus(0, OFS_STATUS, 0);
		check(a, r);
		cnt_run = 1'b1;
		stall <= 1'b0;
		repeat (400) @(posedge hclk);
		cnt_run = 1'b0;
		// buffer, output register and the read before the first step
		check(FIFO_D + 2, same_n);
		check(1, diverged);
		bus(1, OFS_MOD_RATE, 0);
		for (i = 0; i < 3; i++) begin
			k = $random(seed);
			k[0] = (i == 1);
			for (n = 0; n < 256; n++) begin
				bus(1, OFS_MODRAM_WR, {8'h00, 8'(n), k[15:0]});
			end
			bus(1, OFS_CTRL, 32'h0000_0400 | ((i == 0 ? 32'd1 : 32'd4) << 7));
			repeat (100) @(posedge hclk);
			check(i == 0 ? k[15:4] : {12{k[0]}}, am_level);
		end
		// fm on a zero base step: each sample adds table times deviation
		k = $random(seed);
		mm = {17'h0_0000, k[14:0]};
		dh = {{16{k[31]}}, k[31:16]};
		bus(1, OFS_STEP_HI, 0);
		bus(1, OFS_MOD_DEV, {k[31:16], 16'h0000});
		for (n = 0; n < 256; n++) begin
			bus(1, OFS_MODRAM_WR, {8'h00, 8'(n), mm[15:0]});
		end
		bus(1, OFS_CTRL, 32'h0000_0500);
		repeat (10) @(posedge hclk);
		bus(0, OFS_STATUS, 0);
		a = r;
		repeat (47) @(posedge hclk);
		bus(0, OFS_STATUS, 0);
		check(a + 10 * mm * dh, r);
		// pm: the table value is a one-off jump of the upper phase bits
		bus(1, OFS_CTRL, 0);
		repeat (5) @(posedge hclk);
		bus(0, OFS_STATUS, 0);
		a = r;
		bus(1, OFS_CTRL, 32'h0000_0580);
		repeat (20) @(posedge hclk);
		bus(0, OFS_STATUS, 0);
		check(a + {mm[15:0], 16'h0000}, r);
		chk_sync = 1'b1;
		repeat (30) begin
			@(posedge hclk);
			comp_in <= 1'($random(seed));
		end
		@(posedge hclk);
		chk_sync = 1'b0;
		close_out;
	end
endmodule
`default_nettype wire
